// ### verilog/cpt_timer_pair.sv
// Complementary three-phase PWM timer pair with APB registers.
// Assumes a synchronous APB master on pclk and gate drivers on the pins.
`timescale 1ns/1ns
`include "cpt_regs.svh"
`default_nettype none
module cpt_timer_pair (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic alt_pos_level,
  input wire logic alt_neg_level,
  output logic ch3_pin_a,
  output logic ch3_pin_b,
  output logic ch3_pin_d,
  output logic ch4_pin_a,
  output logic ch4_pin_c,
  output logic ch4_pin_b,
  output logic ch4_pin_d,
  output logic adc0_clk_en
);
  // -------------------------------------------------------------------
  // Register state
  // -------------------------------------------------------------------
  logic [7:0] ctrl3_q;
  logic [7:0] ctrl4_q;
  logic [3:0] mode3_q;
  logic [15:0] cnt3_q;
  logic [15:0] cnt4_q;
  logic [15:0] per_q;
  logic [15:0] duty3_q;
  logic [15:0] per_buf_q;
  logic [15:0] duty3_buf_q;
  logic [15:0] duty4a_q;
  logic [15:0] duty4b_q;
  logic [15:0] duty4a_buf_q;
  logic [15:0] duty4b_buf_q;
  logic [15:0] dead_q;
  logic [15:0] cyc_q;
  logic [15:0] cyc_buf_q;
  logic [7:0] ocr1_q;
  logic [7:0] stby_q;
  logic start_q;
  cpt_pkg::cpt_dir_t dir3_q;
  cpt_pkg::cpt_dir_t dir4_q;
  logic [5:0] psc_q;
  logic toggle_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic adc0_en_q;

  // -------------------------------------------------------------------
  // Bus decode
  // -------------------------------------------------------------------
  wire access = psel && penable;
  wire wr_en = access && pready_q && pwrite;
  wire hit_ctrl3 = paddr == `CPT_OFF_CTRL3;
  wire hit_ctrl4 = paddr == `CPT_OFF_CTRL4;
  wire hit_mode3 = paddr == `CPT_OFF_MODE3;
  wire hit_cnt3 = paddr == `CPT_OFF_CNT3;
  wire hit_cnt4 = paddr == `CPT_OFF_CNT4;
  wire hit_per = paddr == `CPT_OFF_PER;
  wire hit_duty3 = paddr == `CPT_OFF_DUTY3;
  wire hit_perbuf = paddr == `CPT_OFF_PERBUF;
  wire hit_duty3buf = paddr == `CPT_OFF_DUTY3BUF;
  wire hit_duty4a = paddr == `CPT_OFF_DUTY4A;
  wire hit_duty4b = paddr == `CPT_OFF_DUTY4B;
  wire hit_duty4abuf = paddr == `CPT_OFF_DUTY4ABUF;
  wire hit_duty4bbuf = paddr == `CPT_OFF_DUTY4BBUF;
  wire hit_dead = paddr == `CPT_OFF_DEAD;
  wire hit_cyc = paddr == `CPT_OFF_CYC;
  wire hit_cycbuf = paddr == `CPT_OFF_CYCBUF;
  wire hit_ocr1 = paddr == `CPT_OFF_OCR1;
  wire hit_stby = paddr == `CPT_OFF_STBY;
  wire hit_start = paddr == `CPT_OFF_START;
  wire hit_status = paddr == `CPT_OFF_STATUS;
  wire mapped = hit_ctrl3 | hit_ctrl4 | hit_mode3 | hit_cnt3 | hit_cnt4
    | hit_per | hit_duty3 | hit_perbuf | hit_duty3buf | hit_duty4a
    | hit_duty4b | hit_duty4abuf | hit_duty4bbuf | hit_dead | hit_cyc
    | hit_cycbuf | hit_ocr1 | hit_stby | hit_start | hit_status;
  wire w16 = wr_en && mapped;

  wire [31:0] rd_mux =
    hit_ctrl3 ? {24'h000000, ctrl3_q} :
    hit_ctrl4 ? {24'h000000, ctrl4_q} :
    hit_mode3 ? {28'h0000000, mode3_q} :
    hit_cnt3 ? {16'h0000, cnt3_q} :
    hit_cnt4 ? {16'h0000, cnt4_q} :
    hit_per ? {16'h0000, per_q} :
    hit_duty3 ? {16'h0000, duty3_q} :
    hit_perbuf ? {16'h0000, per_buf_q} :
    hit_duty3buf ? {16'h0000, duty3_buf_q} :
    hit_duty4a ? {16'h0000, duty4a_q} :
    hit_duty4b ? {16'h0000, duty4b_q} :
    hit_duty4abuf ? {16'h0000, duty4a_buf_q} :
    hit_duty4bbuf ? {16'h0000, duty4b_buf_q} :
    hit_dead ? {16'h0000, dead_q} :
    hit_cyc ? {16'h0000, cyc_q} :
    hit_cycbuf ? {16'h0000, cyc_buf_q} :
    hit_ocr1 ? {24'h000000, ocr1_q} :
    hit_stby ? {24'h000000, stby_q} :
    hit_start ? {31'h00000000, start_q} :
    hit_status ? {29'h00000000, toggle_q, dir4_q == cpt_pkg::CPT_DOWN,
                  dir3_q == cpt_pkg::CPT_DOWN} :
    32'h00000000;

  // -------------------------------------------------------------------
  // Run control and prescaler
  // -------------------------------------------------------------------
  wire tmr_clk_on = !stby_q[`CPT_STBY_TMR];
  wire cpwm = mode3_q == `CPT_MODE_CPWM3;
  wire run = start_q && cpwm && tmr_clk_on;

  function automatic logic psc_tick(input logic [2:0] sel, input logic [5:0] div);
    case (sel)
      `CPT_PSC_DIV1: psc_tick = 1'b1;
      `CPT_PSC_DIV4: psc_tick = &div[1:0];
      `CPT_PSC_DIV16: psc_tick = &div[3:0];
      `CPT_PSC_DIV64: psc_tick = &div;
      default: psc_tick = 1'b1;
    endcase
  endfunction

  // Only internal sources exist, so every edge setting counts the tick;
  // the rising-edge code is the defined one.
  wire edge3_ok = (ctrl3_q[4:3] == `CPT_EDGE_RISE) || 1'b1;
  wire edge4_ok = (ctrl4_q[4:3] == `CPT_EDGE_RISE) || 1'b1;
  wire tick3 = run && edge3_ok && psc_tick(ctrl3_q[2:0], psc_q);
  wire tick4 = run && edge4_ok && psc_tick(ctrl4_q[2:0], psc_q);

  // -------------------------------------------------------------------
  // Counter events
  // -------------------------------------------------------------------
  wire peak3 = tick3 && dir3_q == cpt_pkg::CPT_UP && cnt3_q == per_q;
  wire valley3 = tick3 && dir3_q == cpt_pkg::CPT_DOWN && cnt3_q == dead_q;
  wire peak4 = tick4 && dir4_q == cpt_pkg::CPT_UP && cnt4_q == cyc_q;
  wire valley4 = tick4 && dir4_q == cpt_pkg::CPT_DOWN && cnt4_q == 16'h0000;
  // Buffers land at the trough so a carrier period never mixes values.
  wire xfer = valley4 || !run;

  // Clear field ignored: compare events never clear a counter.
  wire clr3_none = ctrl3_q[7:5] == `CPT_CLR_NONE;
  wire clr4_none = ctrl4_q[7:5] == `CPT_CLR_NONE;

  // -------------------------------------------------------------------
  // Output control write protect
  // -------------------------------------------------------------------
  wire ocr_wr = w16 && hit_ocr1;
  wire [7:0] ocr_next = {1'b0, pwdata[`CPT_OCR_SYNC], 2'h0,
    ocr1_q[`CPT_OCR_LOCK] | pwdata[`CPT_OCR_LOCK],
    ocr1_q[`CPT_OCR_LOCK] ? ocr1_q[2:0] : pwdata[2:0]};
  wire pos_lvl = ocr1_q[`CPT_OCR_SRC] ? alt_pos_level : ocr1_q[`CPT_OCR_PLVL];
  wire neg_lvl = ocr1_q[`CPT_OCR_SRC] ? alt_neg_level : ocr1_q[`CPT_OCR_NLVL];

  // -------------------------------------------------------------------
  // APB slave, one wait state
  // -------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else if (ce) begin
      pready_q <= access && !pready_q;
      pslverr_q <= access && !pready_q && !mapped;
      if (access && !pready_q && !pwrite) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // -------------------------------------------------------------------
  // Control registers
  // -------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl3_q <= `CPT_RST_CTRL;
      ctrl4_q <= `CPT_RST_CTRL;
      mode3_q <= 4'h0;
      ocr1_q <= `CPT_RST_OCR1;
      stby_q <= `CPT_RST_STBY;
      start_q <= 1'b0;
      dead_q <= `CPT_RST_WORD;
    end else if (ce) begin
      if (w16 && hit_ctrl3) ctrl3_q <= pwdata[7:0];
      if (w16 && hit_ctrl4) ctrl4_q <= pwdata[7:0];
      if (w16 && hit_mode3) mode3_q <= pwdata[3:0];
      if (ocr_wr) ocr1_q <= ocr_next;
      if (w16 && hit_stby) stby_q <= pwdata[7:0];
      if (w16 && hit_start) start_q <= pwdata[0];
      if (w16 && hit_dead) dead_q <= pwdata[15:0];
    end
  end

  // -------------------------------------------------------------------
  // Buffers and compares
  // -------------------------------------------------------------------
  // Software keeps buffers equal to compares before start, so the first
  // trough transfer leaves the waveform alone.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_buf_q <= `CPT_RST_WORD;
      duty3_buf_q <= `CPT_RST_WORD;
      duty4a_buf_q <= `CPT_RST_WORD;
      duty4b_buf_q <= `CPT_RST_WORD;
      cyc_buf_q <= `CPT_RST_WORD;
    end else if (ce) begin
      if (w16 && hit_perbuf) per_buf_q <= pwdata[15:0];
      if (w16 && hit_duty3buf) duty3_buf_q <= pwdata[15:0];
      if (w16 && hit_duty4abuf) duty4a_buf_q <= pwdata[15:0];
      if (w16 && hit_duty4bbuf) duty4b_buf_q <= pwdata[15:0];
      if (w16 && hit_cycbuf) cyc_buf_q <= pwdata[15:0];
    end
  end

  // Direct writes win over trough transfers, whether stopped or running.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_q <= `CPT_RST_WORD;
      duty3_q <= `CPT_RST_WORD;
      duty4a_q <= `CPT_RST_WORD;
      duty4b_q <= `CPT_RST_WORD;
      cyc_q <= `CPT_RST_WORD;
    end else if (ce) begin
      if (w16 && hit_per) per_q <= pwdata[15:0];
      else if (valley4) per_q <= per_buf_q;
      if (w16 && hit_duty3) duty3_q <= pwdata[15:0];
      else if (valley4) duty3_q <= duty3_buf_q;
      if (w16 && hit_duty4a) duty4a_q <= pwdata[15:0];
      else if (valley4) duty4a_q <= duty4a_buf_q;
      if (w16 && hit_duty4b) duty4b_q <= pwdata[15:0];
      else if (valley4) duty4b_q <= duty4b_buf_q;
      if (w16 && hit_cyc) cyc_q <= pwdata[15:0];
      else if (xfer && run) cyc_q <= cyc_buf_q;
    end
  end

  // -------------------------------------------------------------------
  // Counters
  // -------------------------------------------------------------------
  // Start expects channel 3 preset to dead time and channel 4 to zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psc_q <= 6'h00;
      cnt3_q <= `CPT_RST_WORD;
      cnt4_q <= `CPT_RST_WORD;
      dir3_q <= cpt_pkg::CPT_UP;
      dir4_q <= cpt_pkg::CPT_UP;
      toggle_q <= 1'b0;
    end else if (ce) begin
      psc_q <= run ? psc_q + 6'h01 : 6'h00;
      if (w16 && hit_cnt3) begin
        cnt3_q <= pwdata[15:0];
      end else if (peak3) begin
        dir3_q <= cpt_pkg::CPT_DOWN;
        cnt3_q <= cnt3_q - 16'h0001;
      end else if (valley3) begin
        dir3_q <= cpt_pkg::CPT_UP;
        cnt3_q <= cnt3_q + 16'h0001;
      end else if (tick3 && clr3_none) begin
        cnt3_q <= dir3_q == cpt_pkg::CPT_UP ? cnt3_q + 16'h0001 : cnt3_q - 16'h0001;
      end else if (tick3) begin
        cnt3_q <= dir3_q == cpt_pkg::CPT_UP ? cnt3_q + 16'h0001 : cnt3_q - 16'h0001;
      end
      if (w16 && hit_cnt4) begin
        cnt4_q <= pwdata[15:0];
      end else if (peak4) begin
        dir4_q <= cpt_pkg::CPT_DOWN;
        cnt4_q <= cnt4_q - 16'h0001;
      end else if (valley4) begin
        dir4_q <= cpt_pkg::CPT_UP;
        cnt4_q <= cnt4_q + 16'h0001;
      end else if (tick4 && clr4_none) begin
        cnt4_q <= dir4_q == cpt_pkg::CPT_UP ? cnt4_q + 16'h0001 : cnt4_q - 16'h0001;
      end else if (tick4) begin
        cnt4_q <= dir4_q == cpt_pkg::CPT_UP ? cnt4_q + 16'h0001 : cnt4_q - 16'h0001;
      end
      if (!ocr1_q[`CPT_OCR_SYNC]) toggle_q <= 1'b0;
      else if (peak3) toggle_q <= !toggle_q;
    end
  end

  // -------------------------------------------------------------------
  // Phases with dead time
  // -------------------------------------------------------------------
  wire [15:0] duty [3];
  assign duty[0] = duty3_q;
  assign duty[1] = duty4a_q;
  assign duty[2] = duty4b_q;
  logic [2:0] pos_act;
  logic [2:0] neg_act;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_phase
      logic want_q;
      logic p_q;
      logic n_q;
      logic [15:0] gap_q;
      wire want = duty[g] > cnt4_q;
      // Any change drops both sides first, so they never overlap.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          want_q <= 1'b0;
          p_q <= 1'b0;
          n_q <= 1'b0;
          gap_q <= 16'h0000;
        end else if (ce) begin
          if (!run) begin
            want_q <= 1'b0;
            p_q <= 1'b0;
            n_q <= 1'b0;
            gap_q <= dead_q;
          end else if (want != want_q) begin
            want_q <= want;
            p_q <= 1'b0;
            n_q <= 1'b0;
            gap_q <= dead_q;
          end else if (gap_q != 16'h0000) begin
            if (tick4) gap_q <= gap_q - 16'h0001;
          end else begin
            p_q <= want_q;
            n_q <= !want_q;
          end
        end
      end
      assign pos_act[g] = p_q;
      assign neg_act[g] = n_q;
    end
  endgenerate

  // -------------------------------------------------------------------
  // Pin drivers
  // -------------------------------------------------------------------
  // Pin routing by port mode code 001 lives outside this block.
  // Level bit 1 means active high; an idle pin shows the inactive level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch3_pin_a <= 1'b0;
      ch3_pin_b <= 1'b0;
      ch3_pin_d <= 1'b0;
      ch4_pin_a <= 1'b0;
      ch4_pin_c <= 1'b0;
      ch4_pin_b <= 1'b0;
      ch4_pin_d <= 1'b0;
      adc0_en_q <= 1'b0;
    end else if (ce) begin
      ch3_pin_a <= toggle_q;
      ch3_pin_b <= pos_act[0] ~^ pos_lvl;
      ch3_pin_d <= neg_act[0] ~^ neg_lvl;
      ch4_pin_a <= pos_act[1] ~^ pos_lvl;
      ch4_pin_c <= neg_act[1] ~^ neg_lvl;
      ch4_pin_b <= pos_act[2] ~^ pos_lvl;
      ch4_pin_d <= neg_act[2] ~^ neg_lvl;
      adc0_en_q <= !stby_q[`CPT_STBY_ADC0];
    end
  end

  // Period compare holds half carrier plus dead time, cycle value half
  // the carrier; the counters rely on that to stay a dead time apart.
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign adc0_clk_en = adc0_en_q;
endmodule // cpt_timer_pair
`default_nettype wire

// ### verilog/cpt_regs.svh
// Register offsets, field positions and reset values of the PWM timer pair.
// Assumes APB byte addressing with one 32-bit word per register.
`ifndef CPT_REGS_SVH
`define CPT_REGS_SVH
// ---------------------------------------------------------------------
// Offsets
// ---------------------------------------------------------------------
`define CPT_OFF_CTRL3 8'h00
`define CPT_OFF_CTRL4 8'h04
`define CPT_OFF_MODE3 8'h08
`define CPT_OFF_CNT3 8'h0c
`define CPT_OFF_CNT4 8'h10
`define CPT_OFF_PER 8'h14
`define CPT_OFF_DUTY3 8'h18
`define CPT_OFF_PERBUF 8'h1c
`define CPT_OFF_DUTY3BUF 8'h20
`define CPT_OFF_DUTY4A 8'h24
`define CPT_OFF_DUTY4B 8'h28
`define CPT_OFF_DUTY4ABUF 8'h2c
`define CPT_OFF_DUTY4BBUF 8'h30
`define CPT_OFF_DEAD 8'h34
`define CPT_OFF_CYC 8'h38
`define CPT_OFF_CYCBUF 8'h3c
`define CPT_OFF_OCR1 8'h40
`define CPT_OFF_STBY 8'h44
`define CPT_OFF_START 8'h48
`define CPT_OFF_STATUS 8'h4c
// ---------------------------------------------------------------------
// Fields and codes
// ---------------------------------------------------------------------
`define CPT_PSC_DIV1 3'h0
`define CPT_PSC_DIV4 3'h1
`define CPT_PSC_DIV16 3'h2
`define CPT_PSC_DIV64 3'h3
`define CPT_EDGE_RISE 2'h0
`define CPT_CLR_NONE 3'h0
`define CPT_MODE_CPWM3 4'hf
`define CPT_OCR_SYNC 6
`define CPT_OCR_LOCK 3
`define CPT_OCR_SRC 2
`define CPT_OCR_NLVL 1
`define CPT_OCR_PLVL 0
`define CPT_STBY_TMR 6
`define CPT_STBY_ADC0 0
// ---------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------
`define CPT_RST_CTRL 8'h00
`define CPT_RST_OCR1 8'h00
`define CPT_RST_STBY 8'h41
`define CPT_RST_WORD 16'h0000
`endif

// ### verilog/cpt_pkg.sv
// Types shared by the PWM timer pair.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package cpt_pkg;
  typedef enum logic {CPT_UP, CPT_DOWN} cpt_dir_t;
endpackage
`default_nettype wire

// ### testbench/cpt_pair_assertions.sv
// Port checker for the PWM timer pair: APB answer timing and standby gating.
// Assumes binding to cpt_timer_pair with ce high whenever the bus is busy.
`timescale 1ns/1ns
`default_nettype none
module cpt_pair_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic adc0_clk_en
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic done = psel && penable && pready;
  chk_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_ready_cause: assert property (pready |-> psel && penable)
    else $error("pready without access phase");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_unmapped_err: assert property (done && paddr > 8'h4c |-> pslverr)
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (done && paddr <= 8'h4c && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  chk_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  chk_upper_zero: assert property (done && !pwrite |-> prdata[31:16] == 16'h0)
    else $error("upper read bits not zero");
  chk_read_hold: assert property ($changed(prdata) |-> pready && !pwrite)
    else $error("read data moved outside a read");
  chk_adc_enable: assert property (done && pwrite && paddr == 8'h44 && !pwdata[0] |-> ##[1:3] adc0_clk_en)
    else $error("adc clock not enabled");
  cover property (done && pwrite);
  cover property (done && !pwrite && paddr == 8'h10);
  cover property (pslverr);
  cover property (adc0_clk_en);
endmodule // cpt_pair_chk
`default_nettype wire

// ### testbench/cpt_gate_model.sv
// Gate driver model watching the three complementary pairs and sync pin.
// Assumes the bench tells it which pin level counts as active.
`timescale 1ns/1ns
`default_nettype none
module cpt_gate_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  input wire logic lvl_p,
  input wire logic lvl_n,
  input wire logic [5:0] gate,
  input wire logic tog,
  output logic overlap,
  output logic [15:0] min_gap,
  output logic [15:0] tog_cnt,
  output logic [15:0] hi [3]
);
  // ---------------------------------------------------------------
  // Pair monitor
  // ---------------------------------------------------------------
  // Even bits positive phase, odd bits negative phase
  wire logic [5:0] act = ~(gate ^ {3{lvl_n, lvl_p}});
  logic [5:0] act_q;
  logic tog_q;
  logic [15:0] gap [3];
  always_ff @(posedge pclk) begin
    if (!presetn || clr) begin
      overlap <= 1'b0;
      min_gap <= 16'hffff;
      tog_cnt <= 16'h0;
      act_q <= act;
      tog_q <= tog;
      // Large start so a gap cut by the clear is not taken as short
      for (int i = 0; i < 3; i++) begin
        hi[i] <= 16'h0;
        gap[i] <= 16'h7fff;
      end
    end else begin
      act_q <= act;
      tog_q <= tog;
      if (tog != tog_q) tog_cnt <= tog_cnt + 16'h1;
      for (int i = 0; i < 3; i++) begin
        if (act[2*i] && act[2*i+1]) overlap <= 1'b1;
        if (act[2*i]) hi[i] <= hi[i] + 16'h1;
        gap[i] <= (act[2*i] || act[2*i+1]) ? 16'h0 : gap[i] + 16'h1;
        if (|(act[2*i+:2] & ~act_q[2*i+:2]) && gap[i] < min_gap) min_gap <= gap[i];
      end
    end
  end
endmodule // cpt_gate_model
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the PWM timer pair over APB.
// Assumes the design, its header and the gate driver model are compiled first.
`timescale 1ns/1ns
`include "cpt_regs.svh"
`default_nettype none
module tb;
  // ---------------------------------------------------------------
  // Set-up
  // ---------------------------------------------------------------
  localparam int DEAD = 4;
  localparam int CYC = 40;
  localparam logic [7:0] OW [5] = '{8'h01, 8'h02, 8'h04, 8'h4b, 8'h40};
  localparam logic [7:0] OE [5] = '{8'h01, 8'h02, 8'h04, 8'h4b, 8'h4b};
  localparam logic [5:0] OG [5] = '{6'h2a, 6'h15, 6'h2a, 6'h00, 6'h00};
  // Duty offsets are not evenly spaced, so list them
  localparam logic [7:0] DCMP [3] = '{`CPT_OFF_DUTY3, `CPT_OFF_DUTY4A, `CPT_OFF_DUTY4B};
  localparam logic [7:0] DBUF [3] = '{`CPT_OFF_DUTY3BUF, `CPT_OFF_DUTY4ABUF, `CPT_OFF_DUTY4BBUF};
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic alt_p = 1, alt_n = 0, clr = 0, lvl_p = 1, lvl_n = 1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rdat, v0;
  logic [31:0] prdata;
  logic pready, pslverr, rerr, pin3a, adc_en, overlap;
  logic [15:0] tog_cnt, min_gap, mx, mn;
  logic [15:0] hi [3];
  wire logic [5:0] gate;
  int n_mismatch = 0, n_tests = 0, cyc_cnt = 0;
  always #2 pclk = ~pclk;
  // Pins wired straight to the model, as if each port mode field held 001
  cpt_timer_pair dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .alt_pos_level(alt_p), .alt_neg_level(alt_n), .ch3_pin_a(pin3a),
    .ch3_pin_b(gate[0]), .ch3_pin_d(gate[1]), .ch4_pin_a(gate[2]), .ch4_pin_c(gate[3]),
    .ch4_pin_b(gate[4]), .ch4_pin_d(gate[5]), .adc0_clk_en(adc_en));
  cpt_gate_model drv_u (.pclk(pclk), .presetn(presetn), .clr(clr), .lvl_p(lvl_p), .lvl_n(lvl_n),
    .gate(gate), .tog(pin3a), .overlap(overlap), .min_gap(min_gap), .tog_cnt(tog_cnt), .hi(hi));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request held until pready is sampled high, then released
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask
  task automatic sweep(input logic [7:0] a);
    mx = 16'h0;
    mn = 16'hffff;
    repeat (100) begin
      apb(1'b0, a, 32'h0);
      if (rdat[15:0] > mx) mx = rdat[15:0];
      if (rdat[15:0] < mn) mn = rdat[15:0];
    end
  endtask
  task automatic t_reset();
    rc(`CPT_OFF_CTRL3, 32'h0, "ctrl3");
    rc(`CPT_OFF_CTRL4, 32'h0, "ctrl4");
    rc(`CPT_OFF_OCR1, {24'h0, `CPT_RST_OCR1}, "ocr1");
    rc(`CPT_OFF_STBY, {24'h0, `CPT_RST_STBY}, "standby");
    chk("adc_off", 32'h0, {31'h0, adc_en});
    chk("sync_off", 32'h0, {31'h0, pin3a});
  endtask
  task automatic t_apb();
    wr(8'h80, 32'h5a);
    rc(8'h80, 32'h0, "unmapped_data");
    chk("unmapped_err", 32'h1, {31'h0, rerr});
    wr(`CPT_OFF_DEAD, 32'hffff1234);
    rc(`CPT_OFF_DEAD, 32'h1234, "dead_word");
  endtask
  // Idle pins sit at the inactive level, the inverse of the active one
  task automatic t_levels();
    for (int i = 0; i < 5; i++) begin
      wr(`CPT_OFF_OCR1, {24'h0, OW[i]});
      rc(`CPT_OFF_OCR1, {24'h0, OE[i]}, "ocr1");
      chk("idle_pins", {26'h0, OG[i]}, {26'h0, gate});
    end
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rc(`CPT_OFF_OCR1, 32'h0, "ocr1_unlocked");
  endtask
  task automatic t_pwm();
    wr(`CPT_OFF_CTRL3, {29'h0, `CPT_PSC_DIV4});
    wr(`CPT_OFF_CTRL4, {29'h0, `CPT_PSC_DIV4});
    rc(`CPT_OFF_CTRL4, 32'h1, "ctrl4");
    wr(`CPT_OFF_MODE3, 32'hf);
    wr(`CPT_OFF_DEAD, DEAD);
    wr(`CPT_OFF_CYC, CYC);
    wr(`CPT_OFF_CYCBUF, CYC);
    wr(`CPT_OFF_PER, CYC + DEAD);
    wr(`CPT_OFF_PERBUF, CYC + DEAD);
    for (int i = 0; i < 3; i++) begin
      wr(DCMP[i], 10 * (i + 1));
      wr(DBUF[i], 10 * (i + 1));
    end
    wr(`CPT_OFF_CNT3, DEAD);
    wr(`CPT_OFF_CNT4, 32'h0);
    wr(`CPT_OFF_OCR1, 32'h43);
    wr(`CPT_OFF_STBY, 32'h0);
    wr(`CPT_OFF_START, 32'h1);
    apb(1'b0, `CPT_OFF_CNT4, 32'h0);
    v0 = rdat;
    repeat (60) @(posedge pclk);
    rc(`CPT_OFF_CNT4, v0 + 32'd16, "div4_rate");
    sweep(`CPT_OFF_CNT4);
    chk("cnt4_peak", CYC, {16'h0, mx});
    chk("cnt4_trough", 32'h0, {16'h0, mn});
    sweep(`CPT_OFF_CNT3);
    chk("cnt3_peak", CYC + DEAD, {16'h0, mx});
    chk("cnt3_trough", DEAD, {16'h0, mn});
    chk("adc_on", 32'h1, {31'h0, adc_en});
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (960) @(posedge pclk);
    chk("sync_toggles", 32'h1, {31'h0, tog_cnt >= 16'd2 && tog_cnt <= 16'd3});
    chk("duty_order", 32'h1, {31'h0, hi[0] > 16'h0 && hi[0] < hi[1] && hi[1] < hi[2]});
    chk("overlap", 32'h0, {31'h0, overlap});
    chk("dead_gap", 32'h1, {31'h0, min_gap >= 16'(4 * (DEAD - 1))});
    wr(`CPT_OFF_DUTY3BUF, 32'd30);
    wr(`CPT_OFF_CYCBUF, CYC + 8);
    wr(`CPT_OFF_PERBUF, CYC + 8 + DEAD);
    repeat (700) @(posedge pclk);
    rc(`CPT_OFF_DUTY3, 32'd30, "duty3_loaded");
    rc(`CPT_OFF_CYC, CYC + 8, "cycle_loaded");
    rc(`CPT_OFF_PER, CYC + 8 + DEAD, "period_loaded");
    wr(`CPT_OFF_STBY, 32'h41);
    apb(1'b0, `CPT_OFF_CNT4, 32'h0);
    v0 = rdat;
    repeat (40) @(posedge pclk);
    rc(`CPT_OFF_CNT4, v0, "stopped");
    chk("adc_off", 32'h0, {31'h0, adc_en});
    // Divide by 16, with a freeze that must not count: 64 live cycles
    wr(`CPT_OFF_CTRL4, {29'h0, `CPT_PSC_DIV16});
    wr(`CPT_OFF_CNT4, 32'h0);
    wr(`CPT_OFF_STBY, 32'h0);
    apb(1'b0, `CPT_OFF_CNT4, 32'h0);
    v0 = rdat;
    ce <= 1'b0;
    repeat (40) @(posedge pclk);
    ce <= 1'b1;
    repeat (60) @(posedge pclk);
    rc(`CPT_OFF_CNT4, v0 + 32'd4, "div16_freeze");
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_apb();
    t_levels();
    t_pwm();
    complete_run();
  end
endmodule // tb
bind cpt_timer_pair cpt_pair_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .adc0_clk_en(adc0_clk_en));
`default_nettype wire
